// ### flsc_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
module flsc_cpu_model
    import flsc_pkg::*;
(
    // Clock
    input wire logic clk_in,
    // Command bus
    output logic wr_out,
    output logic rd_out,
    output logic [ADDR_W-1:0] addr_out,
    output logic [DATA_W-1:0] wdata_out
);
    initial begin
        wr_out = 1'h0;
        rd_out = 1'h0;
        addr_out = 20'h00000;
        wdata_out = 16'h0000;
    end

    // One 16-bit bus cycle; idle bus shows the inverse, never a stale word
    task automatic cyc(input logic w, input logic [ADDR_W-1:0] a,
            input logic [DATA_W-1:0] d);
        @(posedge clk_in);
        #1;
        wr_out = w;
        rd_out = !w;
        addr_out = a;
        wdata_out = d;
        @(posedge clk_in);
        #1;
        wr_out = 1'h0;
        rd_out = 1'h0;
        addr_out = ~a;
        wdata_out = ~d;
    endtask
endmodule
`default_nettype wire

// ### flsc_lock_store.sv
`timescale 1ns/100ps
`default_nettype none
module flsc_lock_store
    import flsc_pkg::*;
(
    // Clock and power-on
    input wire logic clk_in,
    input wire logic por_in,
    // Updates
    input wire logic clr_in,
    input wire logic set_in,
    input wire logic [BLK_W-1:0] idx_in,
    // State
    output logic [NUM_BLK-1:0] bits_out
);

    typedef struct packed {
        logic [NUM_BLK-1:0] bits;
    } flsc_store_t;

    flsc_store_t q, d;

    // Lock bits model nonvolatile cells: the sequencer reset leaves
    // them alone; the power-on strobe brings them all to erased, and set_in brings one bit to erased.
    always_comb begin
        d = q;
        if (set_in) begin
            d.bits[idx_in] = LOCK_ERASED;
        end else if (clr_in) begin
            d.bits[idx_in] = ~LOCK_ERASED;
        end
    end

    always_ff @(posedge clk_in) begin
        if (por_in) begin
            q <= '{bits: {NUM_BLK{LOCK_ERASED}}};
        end else begin
            q <= d;
        end
    end

    assign bits_out = q.bits;

endmodule
`default_nettype wire

// ### flsc_pkg.sv
package flsc_pkg;

    ////////////////////////////////////////////////////////////////////
    // Geometry
    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;
    localparam int BLK_W = 4;
    localparam int BLK_LSB = 16;
    localparam int NUM_BLK = 14;
    localparam logic [BLK_W-1:0] LAST_ERALL_BLK = 4'hC;
    localparam int CNT_W = 8;

    ////////////////////////////////////////////////////////////////////
    // Command codes, low byte of the write data
    localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_PROGRAM = 8'h40;
    localparam logic [7:0] CMD_BLOCK_ERASE = 8'h20;
    localparam logic [7:0] CMD_ERASE_ALL = 8'hA7;
    localparam logic [7:0] CMD_LOCK_PROG = 8'h77;
    localparam logic [7:0] CMD_READ_LOCK = 8'h71;
    localparam logic [7:0] CMD_CONFIRM = 8'hD0;

    ////////////////////////////////////////////////////////////////////
    // Status byte layout and values after reset
    localparam int SEQ_BIT = 7;
    localparam int ERASE_BIT = 5;
    localparam int PROG_BIT = 4;
    localparam logic SEQ_RST = 1'b1;
    localparam logic ERR_RST = 1'b0;
    localparam logic LOCK_ERASED = 1'b1;

    ////////////////////////////////////////////////////////////////////
    // Operation times
    localparam int CLK_PERIOD_PS = 4000;
    localparam int PROG_TIME_NS = 40;
    localparam int ERASE_TIME_NS = 100;
    localparam int LOCK_TIME_NS = 40;
    localparam logic [CNT_W-1:0] PROG_CYC = CNT_W'(
        (PROG_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [CNT_W-1:0] ERASE_CYC = CNT_W'(
        (ERASE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [CNT_W-1:0] LOCK_CYC = CNT_W'(
        (LOCK_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

    ////////////////////////////////////////////////////////////////////
    // Sequencer states and operation kinds
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_SECOND = 3'h2,
        ST_BUSY = 3'h4
    } flsc_state_t;

    typedef enum logic [1:0] {
        OP_PROG = 2'h0,
        OP_ERASE = 2'h1,
        OP_ERALL = 2'h2,
        OP_LOCK = 2'h3
    } flsc_op_t;

endpackage

// ### flsc_top.sv
//
// Functional notes
// - One retained lock bit per block, honoured when enabled
// - Lock bit 0 blocks program and erase
// - Lock program clears bit; erase or the power-on strobe sets it
// - Lock disable ignores bits without changing them
// - Erase with locks disabled erases, bits read 1
// - Status readable after status or operation command
// - Sequencer flag busy during operation, ready after
// - Status byte: D7 ready, D5 erase, D4 program
// - Clear status zeroes both error flags
// - Error flags refuse program, erase, lock commands
// - Bad command or second cycle: both flags
// - Read-array second cycle aborts to array mode, except after program (taken as data)
// - Locked block erase or erase failure: erase error
// - Program or lock write failure: program error
// - No lock error while locks are disabled
// - Read lock status copies bit to readback
`timescale 1ns/100ps
`default_nettype none
module flsc_top
    import flsc_pkg::*;
(
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic RST_IN,
    input wire logic LOCK_POR_IN,
    // CPU command bus
    input wire logic CMD_WR_IN,
    input wire logic CMD_RD_IN,
    input wire logic [ADDR_W-1:0] ADDR_IN,
    input wire logic [DATA_W-1:0] WDATA_IN,
    output logic [DATA_W-1:0] RDATA_OUT,
    output logic RVALID_OUT,
    // Flash mode register bits
    input wire logic LOCK_DISABLE_CTRL_IN,
    output logic SEQUENCER_READY_MIRROR_OUT,
    output logic ERASE_ERROR_MIRROR_OUT,
    output logic PROGRAM_ERROR_MIRROR_OUT,
    output logic LOCK_STATUS_READBACK_OUT,
    output logic [NUM_BLK-1:0] LOCK_BITS_OUT,
    // Flash array
    input wire logic [DATA_W-1:0] ARRAY_RDATA_IN,
    input wire logic VERIFY_FAIL_IN,
    output logic ARRAY_PROG_OUT,
    output logic ARRAY_ERASE_OUT,
    output logic [ADDR_W-1:0] ARRAY_ADDR_OUT,
    output logic [DATA_W-1:0] ARRAY_WDATA_OUT,
    output logic [BLK_W-1:0] ARRAY_BLOCK_OUT
);

    typedef struct packed {
        flsc_state_t state;
        logic status_mode;
        logic [7:0] pend_code;
        logic [ADDR_W-1:0] pend_addr;
        flsc_op_t op;
        logic prot;
        logic [BLK_W-1:0] blk;
        logic [CNT_W-1:0] cnt;
        logic ready;
        logic erase_err;
        logic prog_err;
        logic lock_rb;
        logic [DATA_W-1:0] rdata;
        logic rvalid;
        logic arr_prog;
        logic arr_erase;
        logic [ADDR_W-1:0] arr_addr;
        logic [DATA_W-1:0] arr_wdata;
        logic lk_clr;
        logic lk_set;
        logic [BLK_W-1:0] lk_idx;
    } flsc_regs_t;

    localparam flsc_regs_t REGS_RST = '{
        state: ST_IDLE,
        status_mode: 1'b0,
        pend_code: 8'h00,
        pend_addr: '0,
        op: OP_PROG,
        prot: 1'b0,
        blk: '0,
        cnt: '0,
        ready: SEQ_RST,
        erase_err: ERR_RST,
        prog_err: ERR_RST,
        lock_rb: LOCK_ERASED,
        rdata: '0,
        rvalid: 1'b0,
        arr_prog: 1'b0,
        arr_erase: 1'b0,
        arr_addr: '0,
        arr_wdata: '0,
        lk_clr: 1'b0,
        lk_set: 1'b0,
        lk_idx: '0
    };

    flsc_regs_t q, d;
    logic [NUM_BLK-1:0] lock_bits;

    ////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [BLK_W-1:0] blk_of(
        input logic [ADDR_W-1:0] addr);
        blk_of = addr[BLK_LSB+BLK_W-1:BLK_LSB];
    endfunction

    // Open when protection is off or the bit reads unlocked
    function automatic logic blk_open(input logic prot,
        input logic [NUM_BLK-1:0] bits, input logic [BLK_W-1:0] idx);
        blk_open = !prot || bits[idx];
    endfunction

    function automatic logic [7:0] status_byte(input flsc_regs_t r);
        status_byte = 8'h00;
        status_byte[SEQ_BIT] = r.ready;
        status_byte[ERASE_BIT] = r.erase_err;
        status_byte[PROG_BIT] = r.prog_err;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Sequencer

    always_comb begin
        logic [7:0] code;
        logic [BLK_W-1:0] bi;
        logic prot_now;
        logic done;
        code = WDATA_IN[7:0];
        bi = blk_of(ADDR_IN);
        prot_now = !LOCK_DISABLE_CTRL_IN;
        done = 1'b0;
        d = q;
        d.rvalid = 1'b0;
        d.arr_prog = 1'b0;
        d.arr_erase = 1'b0;
        d.lk_clr = 1'b0;
        d.lk_set = 1'b0;

        if (CMD_RD_IN) begin
            d.rvalid = 1'b1;
            if (q.status_mode) begin
                d.rdata = {8'h00, status_byte(q)};
            end else begin
                d.rdata = ARRAY_RDATA_IN;
            end
        end

        case (q.state)
            ST_IDLE: begin
                if (CMD_WR_IN) begin
                    if (ADDR_IN[0]) begin
                        d.erase_err = 1'b1;
                        d.prog_err = 1'b1;
                        d.status_mode = 1'b1;
                    end else if (code == CMD_READ_ARRAY) begin
                        d.status_mode = 1'b0;
                    end else if (code == CMD_READ_STATUS) begin
                        d.status_mode = 1'b1;
                    end else if (code == CMD_CLEAR_STATUS) begin
                        d.erase_err = 1'b0;
                        d.prog_err = 1'b0;
                    end else if (code == CMD_PROGRAM ||
                        code == CMD_BLOCK_ERASE ||
                        code == CMD_ERASE_ALL ||
                        code == CMD_LOCK_PROG) begin
                        // Refused silently; software reads status
                        if (!(q.erase_err || q.prog_err)) begin
                            d.pend_code = code;
                            d.pend_addr = ADDR_IN;
                            d.state = ST_SECOND;
                        end
                    end else if (code == CMD_READ_LOCK) begin
                        d.pend_code = code;
                        d.pend_addr = ADDR_IN;
                        d.state = ST_SECOND;
                    end else begin
                        d.erase_err = 1'b1;
                        d.prog_err = 1'b1;
                        d.status_mode = 1'b1;
                    end
                end
            end

            ST_SECOND: begin
                if (CMD_WR_IN) begin
                    d.state = ST_IDLE;
                    d.prot = prot_now;
                    d.blk = bi;
                    if (q.pend_code == CMD_PROGRAM) begin
                        d.status_mode = 1'b1;
                        if (ADDR_IN != q.pend_addr ||
                            bi >= BLK_W'(NUM_BLK)) begin
                            d.erase_err = 1'b1;
                            d.prog_err = 1'b1;
                        end else if (!blk_open(prot_now, lock_bits,
                            bi)) begin
                            d.prog_err = 1'b1;
                        end else begin
                            d.op = OP_PROG;
                            d.arr_prog = 1'b1;
                            d.arr_addr = ADDR_IN;
                            d.arr_wdata = WDATA_IN;
                            d.cnt = PROG_CYC - 1'b1;
                            d.ready = 1'b0;
                            d.state = ST_BUSY;
                        end
                    end else if (code == CMD_READ_ARRAY) begin
                        d.status_mode = 1'b0;
                    end else if (code != CMD_CONFIRM ||
                        ADDR_IN[0] || bi >= BLK_W'(NUM_BLK) ||
                        (q.pend_code == CMD_LOCK_PROG &&
                        ADDR_IN != q.pend_addr)) begin
                        d.erase_err = 1'b1;
                        d.prog_err = 1'b1;
                        d.status_mode = 1'b1;
                    end else if (q.pend_code == CMD_READ_LOCK) begin
                        d.lock_rb = lock_bits[bi];
                    end else begin
                        d.status_mode = 1'b1;
                        d.ready = 1'b0;
                        d.state = ST_BUSY;
                        d.lk_idx = bi;
                        if (q.pend_code == CMD_BLOCK_ERASE) begin
                            d.op = OP_ERASE;
                            if (!blk_open(prot_now, lock_bits, bi)) begin
                                d.erase_err = 1'b1;
                                d.ready = 1'b1;
                                d.state = ST_IDLE;
                            end else begin
                                d.arr_erase = 1'b1;
                                d.cnt = ERASE_CYC - 1'b1;
                            end
                        end else if (q.pend_code == CMD_ERASE_ALL) begin
                            d.op = OP_ERALL;
                            d.blk = '0;
                            d.lk_idx = '0;
                            d.arr_erase = blk_open(prot_now, lock_bits,
                                '0);
                            d.cnt = d.arr_erase ? ERASE_CYC - 1'b1 : '0;
                        end else begin
                            d.op = OP_LOCK;
                            d.cnt = LOCK_CYC - 1'b1;
                        end
                    end
                end
            end

            ST_BUSY: begin
                // Writes during an operation are dropped
                if (q.cnt != '0) begin
                    d.cnt = q.cnt - 1'b1;
                end else begin
                    case (q.op)
                        OP_PROG: begin
                            d.prog_err = q.prog_err || VERIFY_FAIL_IN;
                            done = 1'b1;
                        end
                        OP_ERASE: begin
                            if (VERIFY_FAIL_IN) begin
                                d.erase_err = 1'b1;
                            end else begin
                                d.lk_set = 1'b1;
                            end
                            done = 1'b1;
                        end
                        OP_LOCK: begin
                            if (VERIFY_FAIL_IN) begin
                                d.prog_err = 1'b1;
                            end else begin
                                d.lk_clr = 1'b1;
                            end
                            done = 1'b1;
                        end
                        default: begin
                            if (blk_open(q.prot, lock_bits, q.blk)) begin
                                if (VERIFY_FAIL_IN) begin
                                    d.erase_err = 1'b1;
                                    done = 1'b1;
                                end else begin
                                    d.lk_set = 1'b1;
                                    d.lk_idx = q.blk;
                                end
                            end
                            if (!done) begin
                                if (q.blk == LAST_ERALL_BLK) begin
                                    done = 1'b1;
                                end else begin
                                    d.blk = q.blk + 1'b1;
                                    d.arr_erase = blk_open(q.prot,
                                        lock_bits, d.blk);
                                    d.cnt = d.arr_erase ?
                                        ERASE_CYC - 1'b1 : '0;
                                end
                            end
                        end
                    endcase
                    if (done) begin
                        d.ready = 1'b1;
                        d.state = ST_IDLE;
                    end
                end
            end

            default: begin
                d.state = ST_IDLE;
            end
        endcase
    end

    // Error flags change only on the paths above and on reset
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            q <= REGS_RST;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Lock bit storage

    flsc_lock_store u_lock_store (
        .clk_in(CLK_IN),
        .por_in(LOCK_POR_IN),
        .clr_in(q.lk_clr),
        .set_in(q.lk_set),
        .idx_in(q.lk_idx),
        .bits_out(lock_bits)
    );

    ////////////////////////////////////////////////////////////////////
    // Outputs

    assign RDATA_OUT = q.rdata;
    assign RVALID_OUT = q.rvalid;
    assign SEQUENCER_READY_MIRROR_OUT = q.ready;
    assign ERASE_ERROR_MIRROR_OUT = q.erase_err;
    assign PROGRAM_ERROR_MIRROR_OUT = q.prog_err;
    assign LOCK_STATUS_READBACK_OUT = q.lock_rb;
    assign LOCK_BITS_OUT = lock_bits;
    assign ARRAY_PROG_OUT = q.arr_prog;
    assign ARRAY_ERASE_OUT = q.arr_erase;
    assign ARRAY_ADDR_OUT = q.arr_addr;
    assign ARRAY_WDATA_OUT = q.arr_wdata;
    assign ARRAY_BLOCK_OUT = q.blk;

endmodule
`default_nettype wire

// ### flsc_top_chk.sv
`timescale 1ns/100ps
`default_nettype none
module flsc_top_chk
    import flsc_pkg::*;
(
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic RST_IN,
    input wire logic LOCK_POR_IN,
    // Command bus
    input wire logic CMD_WR_IN,
    input wire logic CMD_RD_IN,
    input wire logic [DATA_W-1:0] WDATA_IN,
    input wire logic RVALID_OUT,
    // Mode bits
    input wire logic LOCK_DISABLE_CTRL_IN,
    input wire logic SEQUENCER_READY_MIRROR_OUT,
    input wire logic ERASE_ERROR_MIRROR_OUT,
    input wire logic PROGRAM_ERROR_MIRROR_OUT,
    input wire logic [NUM_BLK-1:0] LOCK_BITS_OUT,
    // Array strobes
    input wire logic ARRAY_PROG_OUT,
    input wire logic ARRAY_ERASE_OUT,
    input wire logic [ADDR_W-1:0] ARRAY_ADDR_OUT,
    input wire logic [BLK_W-1:0] ARRAY_BLOCK_OUT
);
    wire logic rdy;
    wire logic err;
    wire logic clr;
    assign rdy = SEQUENCER_READY_MIRROR_OUT;
    assign err = ERASE_ERROR_MIRROR_OUT | PROGRAM_ERROR_MIRROR_OUT;
    assign clr = CMD_WR_IN && WDATA_IN[7:0] == CMD_CLEAR_STATUS;

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);

    ////////////////////////////////////////////////////////////////////
    // Busy spans: erase-all may chain blocks 0 to 12, hence the wide bound
    sequence busy_s;
        !rdy [*8];
    endsequence
    sequence prog_done_s;
        busy_s ##1 !rdy [*2] ##1 rdy;
    endsequence
    sequence erase_done_s;
        busy_s ##[1:400] rdy;
    endsequence

    rvalid_pulse_a: assert property (RVALID_OUT == $past(CMD_RD_IN))
        else $error("read answer not one cycle after read");
    prog_busy_a: assert property (ARRAY_PROG_OUT |-> prog_done_s)
        else $error("program busy span wrong");
    erase_busy_a: assert property (ARRAY_ERASE_OUT |-> erase_done_s)
        else $error("erase busy span wrong");
    prog_guard_a: assert property (
        ARRAY_PROG_OUT && !$past(LOCK_DISABLE_CTRL_IN)
        |-> LOCK_BITS_OUT[ARRAY_ADDR_OUT[BLK_LSB+:BLK_W]])
        else $error("locked block programmed");
    erase_guard_a: assert property (
        ARRAY_ERASE_OUT && !$past(LOCK_DISABLE_CTRL_IN)
        |-> LOCK_BITS_OUT[ARRAY_BLOCK_OUT])
        else $error("locked block erased");
    refuse_op_a: assert property (
        $past(err) && $past(rdy) |-> !ARRAY_PROG_OUT && !ARRAY_ERASE_OUT)
        else $error("operation started with error flag set");
    err_hold_a: assert property (
        $fell(ERASE_ERROR_MIRROR_OUT) || $fell(PROGRAM_ERROR_MIRROR_OUT)
        |-> $past(clr) || $past(clr, 2))
        else $error("error flag dropped without clear");
    lock_rise_a: assert property (
        (LOCK_BITS_OUT & ~$past(LOCK_BITS_OUT)) != '0
        |-> $past(LOCK_POR_IN) || $past(LOCK_POR_IN, 2)
            || !$past(rdy, 2))
        else $error("lock bit set outside erase");
endmodule

bind flsc_top flsc_top_chk i_chk (
    .CLK_IN(CLK_IN), .RST_IN(RST_IN), .LOCK_POR_IN(LOCK_POR_IN),
    .CMD_WR_IN(CMD_WR_IN), .CMD_RD_IN(CMD_RD_IN), .WDATA_IN(WDATA_IN),
    .RVALID_OUT(RVALID_OUT), .LOCK_DISABLE_CTRL_IN(LOCK_DISABLE_CTRL_IN),
    .SEQUENCER_READY_MIRROR_OUT(SEQUENCER_READY_MIRROR_OUT),
    .ERASE_ERROR_MIRROR_OUT(ERASE_ERROR_MIRROR_OUT),
    .PROGRAM_ERROR_MIRROR_OUT(PROGRAM_ERROR_MIRROR_OUT),
    .LOCK_BITS_OUT(LOCK_BITS_OUT), .ARRAY_PROG_OUT(ARRAY_PROG_OUT),
    .ARRAY_ERASE_OUT(ARRAY_ERASE_OUT), .ARRAY_ADDR_OUT(ARRAY_ADDR_OUT),
    .ARRAY_BLOCK_OUT(ARRAY_BLOCK_OUT)
);
`default_nettype wire

// ### tb_flash_lock_status_checker.sv
`timescale 1ns/100ps
`default_nettype none
module tb_flash_lock_status_checker
    import flsc_pkg::*;
    ;
    localparam logic [ADDR_W-1:0] A0 = 20'h10100;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic por = 1'h1;
    logic dis = 1'h0;
    logic vfail = 1'h0;
    logic wr, rd, rvalid, rdy, eerr, perr, lrb, aprog, aerase;
    logic [ADDR_W-1:0] addr, aaddr;
    logic [DATA_W-1:0] wdata, rdata, arr, awdata;
    logic [BLK_W-1:0] ablk;
    logic [NUM_BLK-1:0] lk;
    logic [DATA_W-1:0] exp_q[$];
    logic [7:0] codes [4] = '{CMD_PROGRAM, CMD_BLOCK_ERASE,
        CMD_ERASE_ALL, CMD_LOCK_PROG};
    logic [7:0] rnd = 8'h29;
    int n_mismatch = 0;
    int checks = 0;

    initial begin
        forever #2 clk = ~clk;
    end
    assign arr = addr[15:0] ^ 16'hC3C3;

    flsc_cpu_model i_cpu (.clk_in(clk), .wr_out(wr), .rd_out(rd),
        .addr_out(addr), .wdata_out(wdata));

    flsc_top i_dut (.CLK_IN(clk), .RST_IN(rst), .LOCK_POR_IN(por),
        .CMD_WR_IN(wr), .CMD_RD_IN(rd), .ADDR_IN(addr), .WDATA_IN(wdata),
        .RDATA_OUT(rdata), .RVALID_OUT(rvalid),
        .LOCK_DISABLE_CTRL_IN(dis), .SEQUENCER_READY_MIRROR_OUT(rdy),
        .ERASE_ERROR_MIRROR_OUT(eerr), .PROGRAM_ERROR_MIRROR_OUT(perr),
        .LOCK_STATUS_READBACK_OUT(lrb), .LOCK_BITS_OUT(lk),
        .ARRAY_RDATA_IN(arr), .VERIFY_FAIL_IN(vfail),
        .ARRAY_PROG_OUT(aprog), .ARRAY_ERASE_OUT(aerase),
        .ARRAY_ADDR_OUT(aaddr), .ARRAY_WDATA_OUT(awdata),
        .ARRAY_BLOCK_OUT(ablk));

    ////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [ADDR_W-1:0] blk(input logic [BLK_W-1:0] b);
        return {b, 16'hFFFE};
    endfunction
    task automatic chk(input logic [DATA_W-1:0] g, e);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr_c(input logic [ADDR_W-1:0] a, input logic [7:0] c);
        i_cpu.cyc(1'h1, a, {8'h00, c});
    endtask
    // Expectation noted before the read is issued
    task automatic rd_e(input logic [ADDR_W-1:0] a, logic [DATA_W-1:0] e);
        exp_q.push_back(e);
        i_cpu.cyc(1'h0, a, 16'h0000);
    endtask
    task automatic st(input logic [7:0] e);
        wr_c(A0, CMD_READ_STATUS);
        rd_e(A0, {8'h00, e});
    endtask
    task automatic wait_rdy;
        int k;
        k = 0;
        repeat (2) @(negedge clk);
        while (rdy !== 1'h1 && k < 1000) begin
            @(negedge clk);
            k++;
        end
        if (k == 1000) n_mismatch++;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic op(input logic [ADDR_W-1:0] a1, input logic [7:0] c,
            input logic [ADDR_W-1:0] a2, input logic [DATA_W-1:0] d);
        wr_c(a1, c);
        i_cpu.cyc(1'h1, a2, d);
        wait_rdy();
    endtask
    task automatic tally_and_finish;
        $display("checks=%0d mismatches=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(negedge clk) begin
        if (rvalid === 1'h1) chk(rdata, exp_q.pop_front());
    end

    initial begin
        #80000;
        n_mismatch++;
        tally_and_finish();
    end

    initial begin
        logic [ADDR_W-1:0] a;
        repeat (12) @(posedge clk);
        #1;
        rst = 1'h0;
        por = 1'h0;
        rd_e(A0, A0[15:0] ^ 16'hC3C3);
        st(8'h80);
        chk({2'h0, lk}, 16'h3FFF);
        for (int i = 0; i < 3; i++) begin
            rnd = lfsr(rnd);
            a = {4'h1, 7'h00, rnd, 1'h0};
            op(a, CMD_PROGRAM, a, {rnd, ~rnd});
            chk(awdata, {rnd, ~rnd});
            chk(aaddr[15:0], a[15:0]);
            rd_e(a, 16'h0080);
        end
        $display("test program done");
        op(blk(4'h2), CMD_LOCK_PROG, blk(4'h2), 16'h00D0);
        chk({2'h0, lk}, 16'h3FFB);
        for (int b = 2; b < 4; b++) begin
            op(A0, CMD_READ_LOCK, blk(BLK_W'(b)), 16'h00D0);
            chk({15'h0000, lrb}, 16'(b - 2));
        end
        op(blk(4'h2) - 20'h2, CMD_PROGRAM, blk(4'h2) - 20'h2, 16'h1234);
        rd_e(A0, 16'h0090);
        wr_c(A0, CMD_CLEAR_STATUS);
        st(8'h80);
        op(A0, CMD_BLOCK_ERASE, blk(4'h2), 16'h00D0);
        rd_e(A0, 16'h00A0);
        chk({14'h0000, eerr, perr}, 16'h0002);
        foreach (codes[i]) begin
            wr_c(blk(4'h5), codes[i]);
            st(8'hA0);
        end
        wr_c(A0, CMD_CLEAR_STATUS);
        $display("test lock done");
        for (int i = 1; i < 4; i++) begin
            op(blk(4'h5), codes[i], blk(4'h5), 16'h0055);
            rd_e(A0, 16'h00B0);
            wr_c(A0, CMD_CLEAR_STATUS);
            wr_c(blk(4'h5), codes[i]);
            wr_c(blk(4'h5), CMD_READ_ARRAY);
            rd_e(A0, A0[15:0] ^ 16'hC3C3);
            st(8'h80);
        end
        wr_c(A0 + 20'h1, CMD_READ_STATUS);
        rd_e(A0, 16'h00B0);
        wr_c(A0, CMD_CLEAR_STATUS);
        $display("test sequence done");
        dis = 1'h1;
        op(blk(4'h2) - 20'h2, CMD_PROGRAM, blk(4'h2) - 20'h2, 16'hBEEF);
        rd_e(A0, 16'h0080);
        chk({2'h0, lk}, 16'h3FFB);
        op(A0, CMD_BLOCK_ERASE, blk(4'h2), 16'h00D0);
        rd_e(A0, 16'h0080);
        chk({2'h0, lk}, 16'h3FFF);
        dis = 1'h0;
        op(blk(4'h2), CMD_LOCK_PROG, blk(4'h2), 16'h00D0);
        op(blk(4'hD), CMD_LOCK_PROG, blk(4'hD), 16'h00D0);
        op(A0, CMD_ERASE_ALL, A0, 16'h00D0);
        rd_e(A0, 16'h0080);
        chk({2'h0, lk}, 16'h1FFB);
        dis = 1'h1;
        op(A0, CMD_ERASE_ALL, A0, 16'h00D0);
        chk({2'h0, lk}, 16'h1FFF);
        op(A0, CMD_BLOCK_ERASE, blk(4'hD), 16'h00D0);
        chk({2'h0, lk}, 16'h3FFF);
        chk({12'h000, ablk}, 16'h000D);
        dis = 1'h0;
        $display("test disable done");
        vfail = 1'h1;
        op(A0, CMD_PROGRAM, A0, 16'h0F0F);
        rd_e(A0, 16'h0090);
        chk({14'h0000, eerr, perr}, 16'h0001);
        wr_c(A0, CMD_CLEAR_STATUS);
        op(A0, CMD_BLOCK_ERASE, blk(4'h4), 16'h00D0);
        rd_e(A0, 16'h00A0);
        wr_c(A0, CMD_CLEAR_STATUS);
        op(blk(4'h6), CMD_LOCK_PROG, blk(4'h6), 16'h00D0);
        vfail = 1'h0;
        st(8'h90);
        wr_c(A0, CMD_CLEAR_STATUS);
        st(8'h80);
        $display("test failure done");
        repeat (4) @(posedge clk);
        tally_and_finish();
    end
endmodule
`default_nettype wire
